/* inc/lcdcd_pkg.sv */
package lcdcd_pkg;

    // geometry of the display store
    localparam int PAGE_W  = 4;
    localparam int COL_W   = 8;
    localparam int NPAGES  = 9;
    localparam int NCOLS   = 132;
    localparam int RAM_N   = NPAGES * NCOLS;
    localparam int RAM_AW  = 11;

    // command byte patterns and masks
    localparam logic [7:0] CMD_DISP_MASK  = 8'hfe;
    localparam logic [7:0] CMD_DISP_VAL   = 8'hae;
    localparam logic [7:0] CMD_START_MASK = 8'hc0;
    localparam logic [7:0] CMD_START_VAL  = 8'h40;
    localparam logic [7:0] CMD_PAGE_MASK  = 8'hf0;
    localparam logic [7:0] CMD_PAGE_VAL   = 8'hb0;
    localparam logic [7:0] CMD_COLH_VAL   = 8'h10;
    localparam logic [7:0] CMD_COLL_VAL   = 8'h00;
    localparam logic [7:0] CMD_ADC_VAL    = 8'ha0;
    localparam logic [7:0] CMD_INV_VAL    = 8'ha6;
    localparam logic [7:0] CMD_ALL_VAL    = 8'ha4;
    localparam logic [7:0] CMD_BIAS_VAL   = 8'ha2;
    localparam logic [7:0] CMD_RMW        = 8'he0;
    localparam logic [7:0] CMD_END        = 8'hee;
    localparam logic [7:0] CMD_RESET      = 8'he2;
    localparam logic [7:0] CMD_NOP        = 8'he3;
    localparam logic [7:0] CMD_COM_MASK   = 8'hf0;
    localparam logic [7:0] CMD_COM_VAL    = 8'hc0;
    localparam logic [7:0] CMD_PWR_MASK   = 8'hf8;
    localparam logic [7:0] CMD_PWR_VAL    = 8'h28;
    localparam logic [7:0] CMD_REG_VAL    = 8'h20;
    localparam logic [7:0] CMD_VOL        = 8'h81;
    localparam logic [7:0] CMD_BOOST      = 8'hf8;
    localparam logic [7:0] CMD_TEST_MASK  = 8'hf0;
    localparam logic [7:0] CMD_TEST_VAL   = 8'hf0;

    // reset values of the settings
    localparam logic [5:0] RST_VOLUME     = 6'h20;
    localparam logic [2:0] RST_REG_RATIO  = 3'h0;
    localparam logic [1:0] RST_BOOST      = 2'h0;

    // status bit positions in the status byte
    localparam int ST_BUSY  = 7;
    localparam int ST_ADC   = 6;
    localparam int ST_ONOFF = 5;
    localparam int ST_RESET = 4;

    // host bus decoder state
    typedef enum logic [2:0] {
        LCDCD_IDLE = 3'b001,
        LCDCD_VOL2 = 3'b010,
        LCDCD_BST2 = 3'b100
    } lcdcd_seq_t;

    // settings that steer the panel driver
    typedef struct packed {
        logic       display_on;
        logic [5:0] start_line;
        logic       seg_reverse;
        logic       invert;
        logic       all_on;
        logic       bias_7;
        logic       com_reverse;
        logic [2:0] power_ctrl;
        logic [2:0] reg_ratio;
        logic [5:0] volume;
        logic [1:0] boost;
        logic       power_save;
    } lcdcd_cfg_t;

    // one accepted host byte
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       is_data;
        logic [7:0] data;
    } lcdcd_xfer_t;

endpackage

/* verilog/lcdcd_host_port.sv */
`timescale 1ns/1ps
// picks parallel or serial host transfer and produces one-cycle byte events
module lcdcd_host_port (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // strap inputs
    input  wire logic                  parallel_select,
    input  wire logic                  host_bus_style_select,
    // host pins
    input  wire logic                  chip_select_n,
    input  wire logic                  command_data_select,
    input  wire logic                  rd_strobe,
    input  wire logic                  wr_strobe,
    input  wire logic [7:0]            data_in,
    input  wire logic                  serial_clk,
    input  wire logic                  serial_in,
    // byte event out
    output lcdcd_pkg::lcdcd_xfer_t     xfer
);

    logic       wr_act;
    logic       rd_act;
    logic       wr_act_q;
    logic       wr_act_d;
    logic       rd_act_q;
    logic       rd_act_d;
    logic       sclk_q;
    logic       sclk_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       ser_done;

    // bus style: style 1 uses separate low strobes, style 0 uses enable and direction
    always_comb begin
        if (host_bus_style_select) begin
            wr_act = !chip_select_n && !wr_strobe;
            rd_act = !chip_select_n && !rd_strobe;
        end else begin
            wr_act = !chip_select_n && rd_strobe && !wr_strobe;
            rd_act = !chip_select_n && rd_strobe && wr_strobe;
        end
    end

    // serial shift on rising serial clock, msb first
    always_comb begin
        wr_act_d = wr_act && parallel_select;
        rd_act_d = rd_act && parallel_select;
        sclk_d   = serial_clk;
        shift_d  = shift_q;
        cnt_d    = cnt_q;
        ser_done = 1'b0;
        if (chip_select_n || parallel_select) begin
            cnt_d = 3'h0;
        end else if (serial_clk && !sclk_q) begin
            shift_d = {shift_q[6:0], serial_in};
            cnt_d   = cnt_q + 3'h1;
            ser_done = (cnt_q == 3'h7);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            sclk_q   <= 1'b0;
            shift_q  <= 8'h00;
            cnt_q    <= 3'h0;
        end else begin
            wr_act_q <= wr_act_d;
            rd_act_q <= rd_act_d;
            sclk_q   <= sclk_d;
            shift_q  <= shift_d;
            cnt_q    <= cnt_d;
        end
    end

    // R20: interface choice
    // R22: command or data mark
    always_comb begin
        xfer.is_data = command_data_select;
        if (parallel_select) begin
            xfer.wr   = wr_act_q && !wr_act;
            xfer.rd   = rd_act && !rd_act_q;
            xfer.data = data_in;
        end else begin
            xfer.wr   = ser_done;
            xfer.rd   = 1'b0;
            xfer.data = {shift_q[6:0], serial_in};
        end
    end

endmodule // lcdcd_host_port

/* verilog/lcdcd_decoder.sv */
`timescale 1ns/1ps
// Behaviour
// R1: display on/off command blanks or shows panel by bit 0
// R2: bytes 01xxxxxx load six-bit display start line
// R3: bytes 1011xxxx load four-bit page address
// R4: column address loaded as upper and lower nibbles by separate commands
// R5: command read returns status in upper nibble, lower nibble zero
// R6: data write stores byte at current page and column
// R7: data read returns RAM byte at current page and column
// R8: segment direction normal on 0, reversed on 1
// R9: inversion off on 0, every pixel inverted on 1
// R10: all points normal on 0, all pixels on on 1
// R11: bias one ninth on 0, one seventh on 1
// R12: read-modify-write: write increments column, read holds; end cancels
// R13: common scan normal on 0, reverse on 1
// R14: power control bits enable supply circuits individually
// R15: regulator ratio bits set divider for drive voltage
// R16: electronic volume mode byte then value byte
// R17: booster command then byte selecting multiplier
// R18: display off plus all points on gives power saving
// R19: host never issues the test command
// R20: pin selects parallel or serial transfer
// R21: strap selects parallel bus style
// R22: select line marks command or data
module lcdcd_decoder (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  reset_pin_n,
    // straps
    input  wire logic                  parallel_select,
    input  wire logic                  host_bus_style_select,
    // host pins
    input  wire logic                  chip_select_n,
    input  wire logic                  command_data_select,
    input  wire logic                  rd_strobe,
    input  wire logic                  wr_strobe,
    input  wire logic [7:0]            data_in,
    output logic      [7:0]            data_out,
    output logic                       data_oe,
    input  wire logic                  serial_clk,
    input  wire logic                  serial_in,
    // panel side read port
    input  wire logic [10:0]           scan_addr,
    output logic      [7:0]            scan_data,
    // settings and addresses out
    output lcdcd_pkg::lcdcd_cfg_t      cfg,
    output logic      [3:0]            page_addr,
    output logic      [7:0]            column_addr,
    output logic                       rmw_active,
    output logic                       test_seen
);

    lcdcd_pkg::lcdcd_xfer_t xfer;
    lcdcd_pkg::lcdcd_cfg_t  cfg_q;
    lcdcd_pkg::lcdcd_cfg_t  cfg_d;
    lcdcd_pkg::lcdcd_seq_t  seq_q;
    lcdcd_pkg::lcdcd_seq_t  seq_d;
    logic [3:0]             page_q;
    logic [3:0]             page_d;
    logic [7:0]             col_q;
    logic [7:0]             col_d;
    logic                   rmw_q;
    logic                   rmw_d;
    logic                   test_q;
    logic                   test_d;
    logic [7:0]             dout_q;
    logic [7:0]             dout_d;
    logic                   soft_rst;
    logic                   hard_rst;
    logic [7:0]             ram_q [lcdcd_pkg::RAM_N];
    logic [10:0]            ram_idx;
    logic [7:0]             cmd;
    logic                   do_cmd;
    logic                   do_wr;
    logic                   do_rd;

    // host transfer front end
    lcdcd_host_port u_port (
        .clk                   (clk),
        .rstn                  (rstn),
        .parallel_select       (parallel_select),
        .host_bus_style_select (host_bus_style_select),
        .chip_select_n         (chip_select_n),
        .command_data_select   (command_data_select),
        .rd_strobe             (rd_strobe),
        .wr_strobe             (wr_strobe),
        .data_in               (data_in),
        .serial_clk            (serial_clk),
        .serial_in             (serial_in),
        .xfer                  (xfer)
    );

    assign hard_rst = !rstn || !reset_pin_n;
    assign cmd      = xfer.data;
    assign do_cmd   = xfer.wr && !xfer.is_data;
    // R6: data write event
    assign do_wr    = xfer.wr && xfer.is_data;
    assign do_rd    = xfer.rd && xfer.is_data;
    assign ram_idx  = 11'(page_q * lcdcd_pkg::NCOLS + col_q);

    // command decoder and address counters
    always_comb begin
        cfg_d    = cfg_q;
        seq_d    = seq_q;
        page_d   = page_q;
        col_d    = col_q;
        rmw_d    = rmw_q;
        test_d   = test_q;
        soft_rst = 1'b0;
        if (do_cmd) begin
            case (seq_q)
                // R16: second byte holds volume
                lcdcd_pkg::LCDCD_VOL2: begin
                    cfg_d.volume = cmd[5:0];
                    seq_d        = lcdcd_pkg::LCDCD_IDLE;
                end
                // R17: second byte holds multiplier
                lcdcd_pkg::LCDCD_BST2: begin
                    cfg_d.boost = cmd[1:0];
                    seq_d       = lcdcd_pkg::LCDCD_IDLE;
                end
                default: begin
                    if ((cmd & lcdcd_pkg::CMD_DISP_MASK) == lcdcd_pkg::CMD_DISP_VAL) begin
                        // R1: display power state
                        cfg_d.display_on = cmd[0];
                    end else if ((cmd & lcdcd_pkg::CMD_START_MASK) == lcdcd_pkg::CMD_START_VAL) begin
                        // R2: start line load
                        cfg_d.start_line = cmd[5:0];
                    end else if ((cmd & lcdcd_pkg::CMD_PAGE_MASK) == lcdcd_pkg::CMD_PAGE_VAL) begin
                        // R3: page address load
                        page_d = cmd[3:0];
                    end else if ((cmd & lcdcd_pkg::CMD_PAGE_MASK) == lcdcd_pkg::CMD_COLH_VAL) begin
                        // R4: upper column nibble
                        col_d = {cmd[3:0], col_q[3:0]};
                    end else if ((cmd & lcdcd_pkg::CMD_PAGE_MASK) == lcdcd_pkg::CMD_COLL_VAL) begin
                        // R4: lower column nibble
                        col_d = {col_q[7:4], cmd[3:0]};
                    end else if ((cmd & lcdcd_pkg::CMD_DISP_MASK) == lcdcd_pkg::CMD_ADC_VAL) begin
                        // R8: segment order
                        cfg_d.seg_reverse = cmd[0];
                    end else if ((cmd & lcdcd_pkg::CMD_DISP_MASK) == lcdcd_pkg::CMD_INV_VAL) begin
                        // R9: pixel inversion
                        cfg_d.invert = cmd[0];
                    end else if ((cmd & lcdcd_pkg::CMD_DISP_MASK) == lcdcd_pkg::CMD_ALL_VAL) begin
                        // R10: all points on
                        cfg_d.all_on = cmd[0];
                    end else if ((cmd & lcdcd_pkg::CMD_DISP_MASK) == lcdcd_pkg::CMD_BIAS_VAL) begin
                        // R11: bias select
                        cfg_d.bias_7 = cmd[0];
                    end else if (cmd == lcdcd_pkg::CMD_RMW) begin
                        // R12: enter read-modify-write
                        rmw_d = 1'b1;
                    end else if (cmd == lcdcd_pkg::CMD_END) begin
                        // R12: end cancels mode
                        rmw_d = 1'b0;
                    end else if (cmd == lcdcd_pkg::CMD_RESET) begin
                        soft_rst = 1'b1;
                    end else if (cmd == lcdcd_pkg::CMD_NOP) begin
                        seq_d = lcdcd_pkg::LCDCD_IDLE;
                    end else if ((cmd & lcdcd_pkg::CMD_COM_MASK) == lcdcd_pkg::CMD_COM_VAL) begin
                        // R13: common scan direction
                        cfg_d.com_reverse = cmd[3];
                    end else if ((cmd & lcdcd_pkg::CMD_PWR_MASK) == lcdcd_pkg::CMD_PWR_VAL) begin
                        // R14: supply circuit enables
                        cfg_d.power_ctrl = cmd[2:0];
                    end else if ((cmd & lcdcd_pkg::CMD_PWR_MASK) == lcdcd_pkg::CMD_REG_VAL) begin
                        // R15: regulator divider ratio
                        cfg_d.reg_ratio = cmd[2:0];
                    end else if (cmd == lcdcd_pkg::CMD_VOL) begin
                        // R16: volume mode byte
                        seq_d = lcdcd_pkg::LCDCD_VOL2;
                    end else if (cmd == lcdcd_pkg::CMD_BOOST) begin
                        // R17: booster mode byte
                        seq_d = lcdcd_pkg::LCDCD_BST2;
                    end else if ((cmd & lcdcd_pkg::CMD_TEST_MASK) == lcdcd_pkg::CMD_TEST_VAL) begin
                        // R19: flag misuse of test code, otherwise ignored
                        test_d = 1'b1;
                    end
                end
            endcase
        end else if (do_wr) begin
            // R12: write always advances column
            col_d = col_q + 8'h01;
        end else if (do_rd && !rmw_q) begin
            // R12: read advances only outside rmw mode
            col_d = col_q + 8'h01;
        end
        // R18: compound power saving state
        cfg_d.power_save = !cfg_d.display_on && cfg_d.all_on;
        if (soft_rst) begin
            cfg_d.start_line  = 6'h00;
            cfg_d.com_reverse = 1'b0;
            cfg_d.reg_ratio   = lcdcd_pkg::RST_REG_RATIO;
            cfg_d.volume      = lcdcd_pkg::RST_VOLUME;
            page_d            = 4'h0;
            col_d             = 8'h00;
            rmw_d             = 1'b0;
            seq_d             = lcdcd_pkg::LCDCD_IDLE;
        end
    end

    // read data: status on command read, RAM byte on data read
    always_comb begin
        dout_d = dout_q;
        if (xfer.rd && !xfer.is_data) begin
            // R5: status in upper nibble
            dout_d = {1'b0, cfg_q.seg_reverse, !cfg_q.display_on, hard_rst, 4'h0};
        end else if (do_rd) begin
            // R7: addressed RAM byte
            dout_d = ram_q[ram_idx];
        end
    end

    always_ff @(posedge clk) begin
        if (hard_rst) begin
            cfg_q    <= '{display_on: 1'b0, start_line: 6'h00, seg_reverse: 1'b0, invert: 1'b0,
                          all_on: 1'b0, bias_7: 1'b0, com_reverse: 1'b0, power_ctrl: 3'h0,
                          reg_ratio: lcdcd_pkg::RST_REG_RATIO, volume: lcdcd_pkg::RST_VOLUME,
                          boost: lcdcd_pkg::RST_BOOST, power_save: 1'b0};
            seq_q    <= lcdcd_pkg::LCDCD_IDLE;
            page_q   <= 4'h0;
            col_q    <= 8'h00;
            rmw_q    <= 1'b0;
            test_q   <= 1'b0;
            dout_q   <= 8'h00;
        end else begin
            cfg_q    <= cfg_d;
            seq_q    <= seq_d;
            page_q   <= page_d;
            col_q    <= col_d;
            rmw_q    <= rmw_d;
            test_q   <= test_d;
            dout_q   <= dout_d;
        end
    end

    // display store, one byte per page and column
    genvar gi;
    for (gi = 0; gi < lcdcd_pkg::RAM_N; gi++) begin : g_ram
        always_ff @(posedge clk) begin
            if (do_wr && ram_idx == 11'(gi)) begin
                ram_q[gi] <= cmd;
            end
        end
    end

    // outputs
    // R21: parallel read drives bus while strobe active, except in the first cycle, while xfer.rd is high
    assign data_oe     = parallel_select && xfer.rd == 1'b0 && !chip_select_n &&
                         (host_bus_style_select ? !rd_strobe : (rd_strobe && wr_strobe));
    assign data_out    = dout_q;
    assign scan_data   = (scan_addr < 11'(lcdcd_pkg::RAM_N)) ? ram_q[scan_addr] : 8'h00;
    assign cfg         = cfg_q;
    assign page_addr   = page_q;
    assign column_addr = col_q;
    assign rmw_active  = rmw_q;
    assign test_seen   = test_q;

endmodule // lcdcd_decoder

/* sim/lcdcd_decoder_chk.sv */
`timescale 1ns/1ps
// checks that settings follow taken host bytes at the decoder pins
module lcdcd_decoder_chk (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  reset_pin_n,
    // straps and host pins
    input wire logic                  parallel_select,
    input wire logic                  host_bus_style_select,
    input wire logic                  chip_select_n,
    input wire logic                  command_data_select,
    input wire logic                  rd_strobe,
    input wire logic                  wr_strobe,
    input wire logic [7:0]            data_in,
    input wire logic [7:0]            data_out,
    // decoder state
    input wire lcdcd_pkg::lcdcd_cfg_t cfg,
    input wire logic [3:0]            page_addr,
    input wire logic [7:0]            column_addr,
    input wire logic                  rmw_active,
    input wire logic                  test_seen
);
    logic wa, ra, take, cmd;
    logic wa_q, ra_q, vol_q, bst_q, vol_d, bst_d;

    // write and read active levels for both strobe styles
    assign wa   = parallel_select && !chip_select_n && !wr_strobe && (host_bus_style_select || rd_strobe);
    assign ra   = parallel_select && !chip_select_n && (host_bus_style_select ? !rd_strobe : rd_strobe && wr_strobe);
    assign take = wa_q && !wa;
    assign cmd  = take && !command_data_select && !vol_q && !bst_q;

    // value byte of a two-byte command pending
    always_comb begin
        vol_d = take ? (cmd && data_in == lcdcd_pkg::CMD_VOL) : vol_q;
        bst_d = take ? (cmd && data_in == lcdcd_pkg::CMD_BOOST) : bst_q;
    end

    // helper registers
    always_ff @(posedge clk) begin
        if (!rstn || !reset_pin_n) begin
            {wa_q, ra_q, vol_q, bst_q} <= 4'h0;
        end else begin
            {wa_q, ra_q, vol_q, bst_q} <= {wa, ra, vol_d, bst_d};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !reset_pin_n);

    disp_power_a: assert property (
        cmd && (data_in & lcdcd_pkg::CMD_DISP_MASK) == lcdcd_pkg::CMD_DISP_VAL |=> cfg.display_on == $past(data_in[0]))
        else $error("display power bit not applied");
    start_line_a: assert property (
        cmd && (data_in & lcdcd_pkg::CMD_START_MASK) == lcdcd_pkg::CMD_START_VAL |=> cfg.start_line == $past(data_in[5:0]))
        else $error("start line not loaded");
    page_load_a: assert property (
        cmd && (data_in & lcdcd_pkg::CMD_PAGE_MASK) == lcdcd_pkg::CMD_PAGE_VAL |=> page_addr == $past(data_in[3:0]))
        else $error("page not loaded");
    status_byte_a: assert property (
        ra && !ra_q && !command_data_select |=> data_out[3:0] == 4'h0 && data_out[6] == cfg.seg_reverse
            && data_out[5] == !cfg.display_on)
        else $error("status byte wrong");
    rmw_write_a: assert property (
        take && command_data_select && rmw_active |=> column_addr == $past(column_addr) + 8'h01)
        else $error("column not advanced on write");
    rmw_read_a: assert property (
        ra && !ra_q && command_data_select && rmw_active |-> ##2 column_addr == $past(column_addr, 2))
        else $error("column moved on read");
    volume_load_a: assert property (
        take && !command_data_select && vol_q |=> cfg.volume == $past(data_in[5:0]))
        else $error("volume not loaded");
    test_ignore_a: assert property (
        cmd && data_in[7:4] == 4'hf && data_in != lcdcd_pkg::CMD_BOOST |=> test_seen && cfg == $past(cfg))
        else $error("test code changed settings");

    // main scenarios
    cover property (cmd && data_in == lcdcd_pkg::CMD_RMW);
    cover property (take && bst_q);
    cover property (ra && !ra_q && command_data_select);
endmodule // lcdcd_decoder_chk

bind lcdcd_decoder lcdcd_decoder_chk lcdcd_decoder_chk_inst (.clk, .rstn, .reset_pin_n, .parallel_select,
    .host_bus_style_select, .chip_select_n, .command_data_select, .rd_strobe, .wr_strobe, .data_in, .data_out,
    .cfg, .page_addr, .column_addr, .rmw_active, .test_seen);

/* sim/lcdcd_host_model.sv */
`timescale 1ns/1ps
// host processor: parallel bytes in either strobe style, serial writes
module lcdcd_host_model (
    // clock and straps
    input  wire logic       clk,
    input  wire logic       parallel_select,
    input  wire logic       host_bus_style_select,
    // device read side
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    // host pins
    output logic            chip_select_n,
    output logic            command_data_select,
    output logic            rd_strobe,
    output logic            wr_strobe,
    output logic      [7:0] data_in,
    output logic            serial_clk,
    output logic            serial_in
);
    logic       h_oe   = 1'b0;
    logic [7:0] h_d    = 8'h00;
    logic [7:0] last_q = 8'h00;

    // resolved bus; nobody driving shows a changing pattern
    assign data_in = h_oe ? h_d : (data_oe ? data_out : ~last_q);

    // last bus value
    always @(posedge clk) begin
        last_q <= data_in;
    end

    // idle levels, serial clock parked low
    initial begin
        {chip_select_n, command_data_select, rd_strobe, wr_strobe, serial_clk, serial_in} = 6'h2c;
    end

    // wait n clock edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one byte out
    task automatic wr_byte(input logic cd, input logic [7:0] d);
        tick(1);
        chip_select_n = 1'b0;
        command_data_select = cd;
        if (parallel_select) begin
            h_d = d;
            h_oe = 1'b1;
            wr_strobe = 1'b0;
            rd_strobe = 1'b1;
            tick(2);
            wr_strobe = 1'b1;
            rd_strobe = host_bus_style_select;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                serial_in = d[i];
                serial_clk = 1'b0;
                tick(2);
                serial_clk = 1'b1;
                tick(2);
            end
            serial_clk = 1'b0;
        end
        tick(1);
        chip_select_n = 1'b1;
        h_oe = 1'b0;
        serial_in = ~serial_in;
        tick(2);
    endtask

    // one byte in, taken while the read is still active
    task automatic rd_byte(input logic cd, output logic [7:0] d);
        tick(1);
        chip_select_n = 1'b0;
        command_data_select = cd;
        rd_strobe = !host_bus_style_select;
        wr_strobe = 1'b1;
        repeat (3) @(posedge clk);
        // take the resolved bus, so a missing output enable shows
        d = data_in;
        #1;
        chip_select_n = 1'b1;
        rd_strobe = host_bus_style_select;
        tick(2);
    endtask
endmodule // lcdcd_host_model

/* sim/lcdcd_decoder_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the command decoder
module lcdcd_decoder_tb;
    logic                  clk = 1'b0, rstn = 1'b0, reset_pin_n = 1'b1;
    logic                  parallel_select = 1'b1, host_bus_style_select = 1'b1;
    logic [10:0]           scan_addr = 11'h000;
    logic                  chip_select_n, command_data_select, rd_strobe, wr_strobe, serial_clk, serial_in;
    logic [7:0]            data_in, data_out, scan_data, column_addr, rd_q;
    logic                  data_oe, rmw_active, test_seen;
    logic [3:0]            page_addr;
    lcdcd_pkg::lcdcd_cfg_t cfg, cfg_q;
    logic [7:0]            ops [6] = '{8'hae, 8'ha0, 8'ha6, 8'ha4, 8'ha2, 8'hc0};
    logic [7:0]            pat [3] = '{8'h5a, 8'ha5, 8'h3c};
    int                    n_fail = 0;
    int                    checks_done = 0;

    `define CMP(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
        $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

    // 40 MHz clock
    always #12.5 clk = ~clk;

    lcdcd_decoder lcdcd_decoder_inst (.*);

    lcdcd_host_model lcdcd_host_model_inst (.*);

    // bus access wrappers
    task automatic wr(input logic cd, input logic [7:0] d);
        lcdcd_host_model_inst.wr_byte(cd, d);
    endtask
    task automatic rd(input logic cd, input logic [7:0] exp);
        lcdcd_host_model_inst.rd_byte(cd, rd_q);
        `CMP(rd_q, exp)
    endtask
    task automatic setcol(input logic [7:0] c);
        wr(1'b0, {4'h1, c[7:4]});
        wr(1'b0, {4'h0, c[3:0]});
    endtask

    // verdict
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t: timeout", $time);
        finish_test();
    end

    // test sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        `CMP({cfg.volume, page_addr, column_addr, cfg.display_on}, {lcdcd_pkg::RST_VOLUME, 12'h000, 1'b0})
        $display("test reset done");
        for (int b = 0; b < 2; b++) begin
            foreach (ops[i]) wr(1'b0, ops[i] | (i == 5 ? 8'(b) << 3 : 8'(b)));
            `CMP({cfg.display_on, cfg.seg_reverse, cfg.invert, cfg.all_on, cfg.bias_7, cfg.com_reverse}, {6{b[0]}})
            rd(1'b0, {1'b0, b[0], !b[0], 5'h00});
        end
        wr(1'b0, 8'hae);
        `CMP(cfg.power_save, 1'b1)
        $display("test modes done");
        wr(1'b0, 8'h7f);
        wr(1'b0, 8'hb8);
        setcol(8'h83);
        `CMP({cfg.start_line, page_addr, column_addr}, {6'h3f, 4'h8, 8'h83})
        $display("test address done");
        scan_addr = 11'd280;
        wr(1'b0, 8'hb2);
        setcol(8'h10);
        foreach (pat[i]) wr(1'b1, pat[i]);
        `CMP({column_addr, scan_data}, {8'h13, 8'h5a})
        setcol(8'h10);
        foreach (pat[i]) rd(1'b1, pat[i]);
        setcol(8'h10);
        wr(1'b0, lcdcd_pkg::CMD_RMW);
        rd(1'b1, 8'h5a);
        `CMP({rmw_active, column_addr}, {1'b1, 8'h10})
        wr(1'b1, 8'h77);
        `CMP({column_addr, scan_data}, {8'h11, 8'h77})
        wr(1'b0, lcdcd_pkg::CMD_END);
        `CMP(rmw_active, 1'b0)
        $display("test ram done");
        for (int v = 0; v < 64; v += 63) begin
            wr(1'b0, lcdcd_pkg::CMD_VOL);
            wr(1'b0, 8'(v));
            `CMP(cfg.volume, 6'(v))
        end
        for (int v = 0; v < 4; v += (v == 0) ? 1 : 2) begin
            wr(1'b0, lcdcd_pkg::CMD_BOOST);
            wr(1'b0, 8'(v));
            `CMP(cfg.boost, 2'(v))
        end
        wr(1'b0, 8'h2f);
        wr(1'b0, 8'h25);
        `CMP({cfg.power_ctrl, cfg.reg_ratio}, {3'h7, 3'h5})
        cfg_q = cfg;
        wr(1'b0, 8'hf3);
        `CMP({test_seen, cfg}, {1'b1, cfg_q})
        $display("test settings done");
        host_bus_style_select = 1'b0;
        wr(1'b0, 8'hb5);
        `CMP(page_addr, 4'h5)
        rd(1'b0, 8'h60);
        parallel_select = 1'b0;
        wr(1'b0, 8'hb3);
        `CMP(page_addr, 4'h3)
        parallel_select = 1'b1;
        host_bus_style_select = 1'b1;
        $display("test host modes done");
        reset_pin_n = 1'b0;
        @(posedge clk);
        #1;
        reset_pin_n = 1'b1;
        `CMP({cfg.volume, page_addr}, {lcdcd_pkg::RST_VOLUME, 4'h0})
        $display("test reset pin done");
        finish_test();
    end
endmodule // lcdcd_decoder_tb
